// file: timer_capture_compare_irq.v
/*
 * Programmable timer: free-running counter, output compare, input capture,
 * control/status register and fixed-priority vector for the internal request line.
 * Assumes a one-cycle read/write strobe per CPU byte access, synchronous to clock_in,
 * and that clock_in is the E clock.
 */
// Functional notes
// - Each internal source gets its own vector; capture, compare, overflow, serial.
// - Test mode zero moves vector addresses into the BFF0 to BFFF range.
// - A pending external request outranks any timer or serial request.
// - Status register reads all eight bits; only bits 0 to 4 are writable.
// - A compare match copies the level bit to the pin when direction selects output.
// - Edge select zero captures falling edges, one captures rising; reset clears it.
// - Three enable bits gate overflow, compare and capture requests; reset clears them.
// - Overflow flag sets at all ones; clears by armed read of count high.
// - Compare flag sets on match; clears by armed write of either compare byte.
// - Capture flag sets on an edge; clears by armed read of capture high.
// - A 16-bit counter advances every cycle except on a count high write, which presets it to FFF8; it is zero during reset.
// - Alternate counter addresses read the count without touching the overflow flag.
// - The compare register is checked against the counter every cycle except the one after a counter high write.
// - Reset loads the compare register with FFFF.
// - Compare matches are suppressed one cycle after a counter high write.
// - Every edge outside a double read updates the capture register, regardless of the capture flag.
// - The edge detector watches the capture pin even when it is an output.
// - Capture transfers are blocked between the two bytes of a double read.
// - The counter drives the serial bit-rate clock; presets may disturb it.
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.vh"

module timer_capture_compare_irq #(
	parameter COUNT_WIDTH = 16
) (
	input  wire        clock_in,
	input  wire        rstn_in,
	input  wire [4:0]  addr_in,
	input  wire [7:0]  wdata_in,
	input  wire        read_in,
	input  wire        write_in,
	input  wire        capture_in_pin_in,
	input  wire        compare_dir_in,
	input  wire        serial_request_in,
	input  wire        external_maskable_request_in,
	input  wire [2:0]  mode_in,
	output reg  [7:0]  rdata_out,
	output reg         compare_out_pin_out,
	output reg         compare_out_pin_oe_out,
	output reg         internal_maskable_request_out,
	output reg  [15:0] vector_addr_out,
	output reg         count_tick_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Control and state.

	reg  [COUNT_WIDTH-1:0] count;
	reg  [15:0]            compare_value;
	reg  [15:0]            capture_value;
	reg                    capture_flag;
	reg                    compare_flag;
	reg                    overflow_flag;
	reg                    capture_irq_enable;
	reg                    compare_irq_enable;
	reg                    overflow_irq_enable;
	reg                    edge_select;
	reg                    output_level_bit;
	reg                    output_level;
	reg                    arm_capture;
	reg                    arm_compare;
	reg                    arm_overflow;
	reg                    compare_hold;
	reg                    double_read;
	wire                   edge_seen;

	wire [7:0] status_byte = {capture_flag, compare_flag, overflow_flag, capture_irq_enable,
		compare_irq_enable, overflow_irq_enable, edge_select, output_level_bit};

	function is_access;
		input [4:0] addr;
		input [4:0] target;
		input       strobe;
		begin
			is_access = strobe & (addr == target);
		end
	endfunction

	wire rd_status    = is_access(addr_in, `ADDR_CTRL_STATUS, read_in);
	wire wr_status    = is_access(addr_in, `ADDR_CTRL_STATUS, write_in);
	wire rd_count_hi  = is_access(addr_in, `ADDR_COUNT_HIGH, read_in);
	wire wr_count_hi  = is_access(addr_in, `ADDR_COUNT_HIGH, write_in);
	wire wr_cmp_hi    = is_access(addr_in, `ADDR_COMPARE_HIGH, write_in);
	wire wr_cmp_lo    = is_access(addr_in, `ADDR_COMPARE_LOW, write_in);
	wire rd_cap_hi    = is_access(addr_in, `ADDR_CAPTURE_HIGH, read_in);
	wire rd_cap_lo    = is_access(addr_in, `ADDR_CAPTURE_LOW, read_in);
	wire rd_alias_hi  = is_access(addr_in, `ADDR_ALIAS_HIGH, read_in);
	wire any_high_rd  = rd_count_hi | rd_cap_hi | rd_alias_hi;
	wire [15:0] count16 = count[15:0];

	////////////////////////////////////////////////////////////////////////////////
	// Capture edge detector.

	capture_edge_detect u_edge (
		.clock_in (clock_in),
		.rstn_in  (rstn_in),
		.pin_in   (capture_in_pin_in),
		.rising_in(edge_select),
		.edge_out (edge_seen)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Counter, compare and capture.

	wire compare_match = (compare_value == count16) & ~compare_hold;
	wire capture_take  = edge_seen & ~double_read;

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count          <= `COUNT_RESET;
			compare_hold   <= 1'b0;
			double_read    <= 1'b0;
			compare_value  <= `COMPARE_RESET;
			capture_value  <= `COUNT_RESET;
			output_level   <= 1'b0;
			count_tick_out <= 1'b0;
		end else begin
			if (wr_count_hi) begin
				count <= `COUNT_PRESET;
			end else begin
				count <= count + 1'b1;
			end
			compare_hold <= wr_count_hi;
			if (any_high_rd) begin
				double_read <= 1'b1;
			end else if (read_in) begin
				double_read <= 1'b0;
			end
			if (wr_cmp_hi) begin
				compare_value[15:8] <= wdata_in;
			end
			if (wr_cmp_lo) begin
				compare_value[7:0] <= wdata_in;
			end
			if (capture_take) begin
				capture_value <= count16;
			end
			if (compare_match) begin
				output_level <= output_level_bit;
			end
			count_tick_out <= count[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control bits and flags.

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			output_level_bit    <= 1'b0;
			edge_select         <= 1'b0;
			overflow_irq_enable <= 1'b0;
			compare_irq_enable  <= 1'b0;
			capture_irq_enable  <= 1'b0;
			overflow_flag       <= 1'b0;
			compare_flag        <= 1'b0;
			capture_flag        <= 1'b0;
			arm_overflow        <= 1'b0;
			arm_compare         <= 1'b0;
			arm_capture         <= 1'b0;
		end else begin
			if (wr_status) begin
				output_level_bit    <= wdata_in[`BIT_LEVEL];
				edge_select         <= wdata_in[`BIT_EDGE];
				overflow_irq_enable <= wdata_in[`BIT_OVF_EN];
				compare_irq_enable  <= wdata_in[`BIT_CMP_EN];
				capture_irq_enable  <= wdata_in[`BIT_CAP_EN];
			end
			if (rd_status) begin
				arm_overflow <= overflow_flag;
				arm_compare  <= compare_flag;
				arm_capture  <= capture_flag;
			end
			if (count16 == `COUNT_ALL_ONES) begin
				overflow_flag <= 1'b1;
			end else if (arm_overflow & rd_count_hi) begin
				overflow_flag <= 1'b0;
				arm_overflow  <= 1'b0;
			end
			if (compare_match) begin
				compare_flag <= 1'b1;
			end else if (arm_compare & (wr_cmp_hi | wr_cmp_lo)) begin
				compare_flag <= 1'b0;
				arm_compare  <= 1'b0;
			end
			if (edge_seen) begin
				capture_flag <= 1'b1;
			end else if (arm_capture & rd_cap_hi) begin
				capture_flag <= 1'b0;
				arm_capture  <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, pin and request outputs.

	reg [7:0]  next_rdata;
	reg [15:0] next_vector;
	wire ovf_req = overflow_flag & overflow_irq_enable;
	wire cmp_req = compare_flag & compare_irq_enable;
	wire cap_req = capture_flag & capture_irq_enable;

	always @* begin
		case (addr_in)
			`ADDR_CTRL_STATUS:  next_rdata = status_byte;
			`ADDR_COUNT_HIGH:   next_rdata = count16[15:8];
			`ADDR_COUNT_LOW:    next_rdata = count16[7:0];
			`ADDR_ALIAS_HIGH:   next_rdata = count16[15:8];
			`ADDR_ALIAS_LOW:    next_rdata = count16[7:0];
			`ADDR_COMPARE_HIGH: next_rdata = compare_value[15:8];
			`ADDR_COMPARE_LOW:  next_rdata = compare_value[7:0];
			`ADDR_CAPTURE_HIGH: next_rdata = capture_value[15:8];
			`ADDR_CAPTURE_LOW:  next_rdata = capture_value[7:0];
			default:            next_rdata = 8'h00;
		endcase
		if (external_maskable_request_in) begin
			next_vector = `VEC_NONE;
		end else if (cap_req) begin
			next_vector = `VEC_CAPTURE;
		end else if (cmp_req) begin
			next_vector = `VEC_COMPARE;
		end else if (ovf_req) begin
			next_vector = `VEC_OVERFLOW;
		end else if (serial_request_in) begin
			next_vector = `VEC_SERIAL;
		end else begin
			next_vector = `VEC_NONE;
		end
		if (mode_in == `TEST_MODE_ZERO) begin
			next_vector = next_vector & `VEC_TEST_BASE_MASK;
		end
	end

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out                     <= 8'h00;
			compare_out_pin_out           <= 1'b0;
			compare_out_pin_oe_out        <= 1'b0;
			internal_maskable_request_out <= 1'b0;
			vector_addr_out               <= `VEC_NONE;
		end else begin
			rdata_out              <= next_rdata;
			compare_out_pin_out    <= output_level;
			compare_out_pin_oe_out <= compare_dir_in;
			internal_maskable_request_out <= ovf_req | cmp_req | cap_req | serial_request_in;
			vector_addr_out               <= next_vector;
		end
	end

endmodule // timer_capture_compare_irq

`default_nettype wire

// file: timer_defines.vh
/*
 * Address map, control field positions, reset values and vector addresses for the
 * programmable timer with hardware interrupt vectoring.
 * Assumes an 8-bit internal register bus with register addresses in the low five bits.
 */
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

`define ADDR_CTRL_STATUS   5'h08
`define ADDR_COUNT_HIGH    5'h09
`define ADDR_COUNT_LOW     5'h0A
`define ADDR_COMPARE_HIGH  5'h0B
`define ADDR_COMPARE_LOW   5'h0C
`define ADDR_CAPTURE_HIGH  5'h0D
`define ADDR_CAPTURE_LOW   5'h0E
`define ADDR_ALIAS_HIGH    5'h15
`define ADDR_ALIAS_LOW     5'h16

`define BIT_LEVEL          0
`define BIT_EDGE           1
`define BIT_OVF_EN         2
`define BIT_CMP_EN         3
`define BIT_CAP_EN         4
`define WRITABLE_BITS      5

`define COUNT_RESET        16'h0000
`define COUNT_PRESET       16'hFFF8
`define COUNT_ALL_ONES     16'hFFFF
`define COMPARE_RESET      16'hFFFF

`define VEC_CAPTURE        16'hFFF6
`define VEC_COMPARE        16'hFFF4
`define VEC_OVERFLOW       16'hFFF2
`define VEC_SERIAL         16'hFFF0
`define VEC_TEST_BASE_MASK 16'hBFFF
`define VEC_NONE           16'h0000
`define TEST_MODE_ZERO     3'h0

`endif

// file: capture_edge_detect.v
/*
 * Edge detector for the capture input.
 * Assumes the pin is synchronous to clock_in and held at least two cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module capture_edge_detect (
	input  wire clock_in,
	input  wire rstn_in,
	input  wire pin_in,
	input  wire rising_in,
	output reg  edge_out
);

	reg prev;

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prev     <= 1'b0;
			edge_out <= 1'b0;
		end else begin
			prev     <= pin_in;
			edge_out <= rising_in ? (pin_in & ~prev) : (~pin_in & prev);
		end
	end

endmodule // capture_edge_detect

`default_nettype wire

// file: capture_pin_source.sv
/* Source model for the capture pin of port 2.
   Assumes its clock is the E clock of the timer block. */
`timescale 1ns/100ps
`default_nettype none
module capture_pin_source (
	input  wire logic clock_in,
	output var  logic pin_out
);
	initial pin_out = 1'b0;
	task automatic drive(input logic level, input int hold);
		@(negedge clock_in);
		pin_out = level;
		repeat (hold) @(negedge clock_in);
	endtask
endmodule // capture_pin_source
`default_nettype wire

// file: timer_capture_compare_irq_properties.sv
/* Port checker for the timer block, bound to its top module.
   Assumes one clock domain and register writes only through write_in. */
`timescale 1ns/100ps
`default_nettype none
module timer_props (
	input wire logic        clock_in,
	input wire logic        rstn_in,
	input wire logic [4:0]  addr_in,
	input wire logic        write_in,
	input wire logic        compare_dir_in,
	input wire logic        serial_request_in,
	input wire logic        external_maskable_request_in,
	input wire logic [2:0]  mode_in,
	input wire logic        compare_out_pin_oe_out,
	input wire logic        internal_maskable_request_out,
	input wire logic [15:0] vector_addr_out,
	input wire logic        count_tick_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	logic wrote_any;
	always_ff @(posedge clock_in or negedge rstn_in)
		if (!rstn_in)
			wrote_any <= 1'b0;
		else if (write_in)
			wrote_any <= 1'b1;
	property p_oe;
		$past(rstn_in) |-> compare_out_pin_oe_out == $past(compare_dir_in);
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	property p_ext;
		external_maskable_request_in && $past(external_maskable_request_in && rstn_in)
			|-> vector_addr_out == 16'h0000;
	endproperty
	a_ext: assert property (p_ext) else $error("vector while external pending");
	property p_test;
		mode_in == 3'h0 && $past(mode_in == 3'h0 && rstn_in) |-> vector_addr_out[15:14] != 2'b11;
	endproperty
	a_test: assert property (p_test) else $error("vector not moved");
	property p_serial;
		serial_request_in && $past(serial_request_in && rstn_in) |-> internal_maskable_request_out;
	endproperty
	a_serial: assert property (p_serial) else $error("request missing");
	property p_gate;
		!wrote_any && !serial_request_in && $past(!serial_request_in)
			|-> !internal_maskable_request_out;
	endproperty
	a_gate: assert property (p_gate) else $error("request without enable");
	property p_vec;
		!wrote_any && $past(serial_request_in && !external_maskable_request_in
			&& mode_in == 3'h1 && rstn_in) |-> vector_addr_out == 16'hfff0;
	endproperty
	a_vec: assert property (p_vec) else $error("serial vector wrong");
	property p_tick;
		$past(rstn_in) && $past(rstn_in, 2) && !$past(write_in) && !$past(write_in, 2)
			|-> count_tick_out != $past(count_tick_out);
	endproperty
	a_tick: assert property (p_tick) else $error("counter not advancing");
	property p_preset;
		write_in && addr_in == 5'h09 |-> ##2 !count_tick_out ##1 count_tick_out;
	endproperty
	a_preset: assert property (p_preset) else $error("preset wrong");
endmodule // timer_props
bind timer_capture_compare_irq timer_props props_i (.clock_in(clock_in), .rstn_in(rstn_in),
	.addr_in(addr_in), .write_in(write_in), .compare_dir_in(compare_dir_in),
	.serial_request_in(serial_request_in),
	.external_maskable_request_in(external_maskable_request_in), .mode_in(mode_in),
	.compare_out_pin_oe_out(compare_out_pin_oe_out),
	.internal_maskable_request_out(internal_maskable_request_out),
	.vector_addr_out(vector_addr_out), .count_tick_out(count_tick_out));
`default_nettype wire

// file: timer_capture_compare_irq_tb.sv
/* Self-checking testbench for the timer block, one task per scenario.
   Assumes the capture pin comes from capture_pin_source. */
`timescale 1ns/100ps
`default_nettype none
module timer_capture_compare_irq_tb;
	logic        clock_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [4:0]  addr_in = 5'h00;
	logic [7:0]  wdata_in = 8'h00;
	logic        read_in = 1'b0;
	logic        write_in = 1'b0;
	logic        pin;
	logic        dir = 1'b0;
	logic        serial = 1'b0;
	logic        ext = 1'b0;
	logic [2:0]  mode = 3'h1;
	logic [7:0]  rdata;
	logic        lvl;
	logic        oe;
	logic        req;
	logic [15:0] vec;
	logic [7:0]  d;
	int          n_errors = 0;
	int          check_count = 0;
	always #50 clock_in = ~clock_in;
	capture_pin_source src (.clock_in(clock_in), .pin_out(pin));
	timer_capture_compare_irq dut (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .read_in(read_in), .write_in(write_in), .capture_in_pin_in(pin),
		.compare_dir_in(dir), .serial_request_in(serial), .external_maskable_request_in(ext),
		.mode_in(mode), .rdata_out(rdata), .compare_out_pin_out(lvl),
		.compare_out_pin_oe_out(oe), .internal_maskable_request_out(req),
		.vector_addr_out(vec), .count_tick_out());
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(negedge clock_in);
		addr_in = a;
		wdata_in = v;
		write_in = 1'b1;
		@(negedge clock_in);
		write_in = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(negedge clock_in);
		addr_in = a;
		read_in = 1'b1;
		@(negedge clock_in);
		read_in = 1'b0;
		d = rdata;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(5'h08);
		chk("status", 16'h0000, {8'h00, d});
		rd(5'h0b);
		chk("cmp high", 16'h00ff, {8'h00, d});
		rd(5'h0c);
		chk("cmp low", 16'h00ff, {8'h00, d});
		$display("test reset done");
	endtask
	task automatic t_serial();
		serial = 1'b1;
		repeat (3) @(negedge clock_in);
		chk("request", 16'h0001, {15'h0000, req});
		chk("vector", 16'hfff0, vec);
		mode = 3'h0;
		repeat (3) @(negedge clock_in);
		chk("test vector", 16'hbff0, vec);
		ext = 1'b1;
		repeat (3) @(negedge clock_in);
		chk("ext vector", 16'h0000, vec);
		{serial, ext, mode} = 5'b0_0001;
		$display("test serial done");
	endtask
	task automatic t_overflow();
		wr(5'h09, 8'h00);
		rd(5'h09);
		chk("count high", 16'h00ff, {8'h00, d});
		repeat (8) @(negedge clock_in);
		rd(5'h08);
		chk("ovf set", 16'h0001, {15'h0000, d[5]});
		rd(5'h15);
		rd(5'h08);
		chk("ovf kept", 16'h0001, {15'h0000, d[5]});
		rd(5'h09);
		rd(5'h08);
		chk("ovf clear", 16'h0000, {15'h0000, d[5]});
		$display("test overflow done");
	endtask
	task automatic t_compare();
		dir = 1'b1;
		rd(5'h08);
		wr(5'h0b, 8'h00);
		wr(5'h0c, 8'h40);
		wr(5'h08, 8'hff);
		rd(5'h08);
		chk("ctrl", 16'h001f, {8'h00, d});
		wr(5'h08, 8'h09);
		wr(5'h09, 8'h00);
		repeat (80) @(negedge clock_in);
		chk("level", 16'h0003, {14'h0000, oe, lvl});
		chk("cmp vector", 16'hfff4, vec);
		rd(5'h08);
		chk("cmp set", 16'h0001, {15'h0000, d[6]});
		wr(5'h0c, 8'h40);
		rd(5'h08);
		chk("cmp clear", 16'h0000, {15'h0000, d[6]});
		chk("no request", 16'h0000, {15'h0000, req});
		$display("test compare done");
	endtask
	task automatic t_suppress();
		wr(5'h0b, 8'hff);
		wr(5'h0c, 8'hf8);
		wr(5'h09, 8'h00);
		repeat (4) @(negedge clock_in);
		rd(5'h08);
		chk("cmp held off", 16'h0000, {15'h0000, d[6]});
		$display("test suppress done");
	endtask
	task automatic t_capture();
		for (int e = 1; e >= 0; e--) begin
			wr(5'h08, {3'b000, 1'b1, 2'b00, e[0], 1'b0});
			src.drive(!e[0], 2);
			src.drive(e[0], 4);
			chk("cap request", 16'h0001, {15'h0000, req});
			rd(5'h08);
			chk("cap set", 16'h0001, {15'h0000, d[7]});
			rd(5'h0d);
			src.drive(!e[0], 2);
			rd(5'h08);
			chk("wrong edge", 16'h0000, {15'h0000, d[7]});
		end
		$display("test capture done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clock_in);
		n_errors++;
		conclude();
	end
	initial begin
		repeat (20) @(negedge clock_in);
		rstn_in = 1'b1;
		t_reset();
		t_serial();
		t_overflow();
		t_compare();
		t_suppress();
		t_capture();
		conclude();
	end
endmodule // timer_capture_compare_irq_tb
`default_nettype wire
